/* File: src/dep_pkg.sv */
/*
 Package for the debug event pin logic: register offsets, field positions,
 select encodings and reset values. Assumes one 25 MHz clock domain.
*/
package dep_pkg;
	localparam int DEP_ADDR_W = 4;
	localparam int DEP_DATA_W = 32;
	localparam logic [DEP_ADDR_W-1:0] DEP_OFF_CTRL = 4'h0;
	localparam logic [DEP_ADDR_W-1:0] DEP_OFF_STATUS = 4'h1;
	localparam logic [DEP_ADDR_W-1:0] DEP_OFF_MASK = 4'h2;
	localparam logic [DEP_ADDR_W-1:0] DEP_OFF_BPEOC = 4'h3;
	localparam int DEP_EIC_LSB = 0;
	localparam int DEP_EOS_LSB = 2;
	localparam int DEP_FLD_W = 2;
	localparam logic [1:0] DEP_EIC_BREAK = 2'h1;
	localparam logic [1:0] DEP_EOS_ENTRY = 2'h1;
	localparam logic [1:0] DEP_EOS_STATUS = 2'h2;
	localparam int DEP_ST_EXB = 0;
	localparam int DEP_ST_ENTRY = 1;
	localparam int DEP_ST_HIT = 2;
	localparam int DEP_ST_W = 3;
	localparam logic [3:0] DEP_CTRL_RST = 4'h0;
	localparam logic [DEP_ST_W-1:0] DEP_ST_RST = 3'h0;
	localparam int DEP_UNITS = 4;
	typedef enum logic [1:0] {
		DEP_EV_IDLE = 2'b00,
		DEP_EV_LOW = 2'b01
	} dep_edge_e;
endpackage

/* File: src/dep_fall_detect.sv */
/*
 Falling edge detector for the event input pin.
 Assumes the pin is already synchronous to mclk.
*/
`timescale 1ns/1ps
module dep_fall_detect
	import dep_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic fall_pulse
);
	logic prev_reg;

	// Reset high, so a pin held low at reset gives one falling edge
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			prev_reg <= 1'b1;
		else
			prev_reg <= pin_in;
	end

	assign fall_pulse = prev_reg & ~pin_in;
endmodule

/* File: src/dep_event_pins.sv */
/*
 Debug event pin logic: event input breakpoint and event output signalling,
 with a small register port and a level interrupt.

 Register indexes on the word-addressed port:
   0  control: bits 1:0 input control, bits 3:2 output select
   1  status: bit 0 external break, bit 1 debug entry, bit 2 enabled unit hit
      (sticky, write one to clear, a new event in the same cycle wins)
   2  interrupt mask, same layout as status
   3  per-unit output-on-condition enables, bit n for unit n
 Unmapped indexes read zero and ignore writes.
 Read data stand for the one cycle after the read strobe and are zero otherwise.

 Output select encodings:
   01  one low cycle on the pin for each debug entry
   10  pin low while any enabled unit reports a hit, one cycle late
   00, 11  pin held high

 Assumes the pins and the CPU debug signals are synchronous to mclk,
 and that a write strobe and a read strobe never stand together.
*/
// Summary of operation
// - With input control 01, a falling edge on the input pin raises a breakpoint.
// - An input-pin breakpoint sets the external break flag in status.
// - Output select 01 drives the output pin low one cycle on debug entry.
// - Units with output-on-condition enabled show their hit status on the output pin.
// - Hit status reaches the output pin only while output select is 10.
`timescale 1ns/1ps
module dep_event_pins
	import dep_pkg::*;
#(
	parameter int UNITS = DEP_UNITS
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [DEP_ADDR_W-1:0] reg_addr,
	input wire logic [DEP_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DEP_DATA_W-1:0] reg_rdata,
	input wire logic event_input_pin,
	output logic event_output_pin,
	input wire logic debug_entry,
	input wire logic [UNITS-1:0] unit_hit,
	output logic ext_break,
	output logic irq
);
	// Unit enables must fit in one register word
	generate
		if (UNITS < 1 || UNITS > DEP_DATA_W)
		begin : g_bad_units
			$error("UNITS out of range");
		end
	endgenerate

	localparam int CTRL_W = 2 * DEP_FLD_W;

	logic [CTRL_W-1:0] debug_control_reg;
	logic [UNITS-1:0] unit_show;
	logic entry_prev_reg;
	logic entry_rise;
	logic [DEP_DATA_W-1:0] rd_word;
	logic [DEP_ST_W-1:0] debug_status_reg;
	logic [DEP_ST_W-1:0] mask_reg;
	logic [UNITS-1:0] eoc_reg;
	logic [DEP_DATA_W-1:0] rdata_reg;
	logic evo_reg;
	logic fall;
	logic [DEP_ST_W-1:0] set_ev;
	logic [1:0] event_in_control;
	logic [1:0] event_out_select;
	logic hit_any;

	function automatic logic sel(input logic [DEP_ADDR_W-1:0] a, input logic [DEP_ADDR_W-1:0] off);
		sel = (a == off);
	endfunction

	assign event_in_control = debug_control_reg[DEP_EIC_LSB +: DEP_FLD_W];
	assign event_out_select = debug_control_reg[DEP_EOS_LSB +: DEP_FLD_W];
	// Event output path: each unit reports only when its enable is set
	generate
		for (genvar u = 0; u < UNITS; u++)
		begin : g_unit
			assign unit_show[u] = unit_hit[u] & eoc_reg[u];
		end
	endgenerate

	assign hit_any = |unit_show;

	// A held debug entry level still gives a single low cycle on the pin
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			entry_prev_reg <= 1'b0;
		else
			entry_prev_reg <= debug_entry;
	end

	assign entry_rise = debug_entry & ~entry_prev_reg;

	// Event input path
	dep_fall_detect u_fall (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_in(event_input_pin),
		.fall_pulse(fall)
	);

	// One-cycle low pin edge suffices since the detector samples every clock
	assign ext_break = fall && (event_in_control == DEP_EIC_BREAK);

	always_comb
	begin
		set_ev = '0;
		set_ev[DEP_ST_EXB] = ext_break;
		set_ev[DEP_ST_ENTRY] = entry_rise;
		set_ev[DEP_ST_HIT] = hit_any;
	end

	// Register port
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			debug_control_reg <= DEP_CTRL_RST;
		else if (reg_wr && sel(reg_addr, DEP_OFF_CTRL))
			debug_control_reg <= reg_wdata[CTRL_W-1:0];
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mask_reg <= DEP_ST_RST;
		else if (reg_wr && sel(reg_addr, DEP_OFF_MASK))
			mask_reg <= reg_wdata[DEP_ST_W-1:0];
	end

	// One enable flop per unit
	generate
		for (genvar e = 0; e < UNITS; e++)
		begin : g_eoc
			always_ff @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
					eoc_reg[e] <= 1'b0;
				else if (reg_wr && sel(reg_addr, DEP_OFF_BPEOC))
					eoc_reg[e] <= reg_wdata[e];
			end
		end
	endgenerate

	// Write one to clear; a new event in the same cycle wins
	generate
		for (genvar b = 0; b < DEP_ST_W; b++)
		begin : g_status
			always_ff @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
					debug_status_reg[b] <= DEP_ST_RST[b];
				else if (set_ev[b])
					debug_status_reg[b] <= 1'b1;
				else if (reg_wr && sel(reg_addr, DEP_OFF_STATUS) && reg_wdata[b])
					debug_status_reg[b] <= 1'b0;
			end
		end
	endgenerate

	assign irq = |(debug_status_reg & mask_reg);

	// Read view of the addressed register; narrow fields sit in the low bits
	always_comb
	begin
		rd_word = '0;
		case (reg_addr)
			DEP_OFF_CTRL: rd_word[CTRL_W-1:0] = debug_control_reg;
			DEP_OFF_STATUS: rd_word[DEP_ST_W-1:0] = debug_status_reg;
			DEP_OFF_MASK: rd_word[DEP_ST_W-1:0] = mask_reg;
			DEP_OFF_BPEOC: rd_word[UNITS-1:0] = eoc_reg;
			default: rd_word = '0;
		endcase
	end

	// Read data stand for one cycle only, zero otherwise
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= '0;
		else if (reg_rd)
			rdata_reg <= rd_word;
		else
			rdata_reg <= '0;
	end

	assign reg_rdata = rdata_reg;

	// Output pin driven from a flop, active low
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			evo_reg <= 1'b1;
		else
		begin
			case (event_out_select)
				DEP_EOS_ENTRY: evo_reg <= ~entry_rise;
				DEP_EOS_STATUS: evo_reg <= ~hit_any;
				default: evo_reg <= 1'b1;
			endcase
		end
	end

	assign event_output_pin = evo_reg;
endmodule

/* File: sim/dep_event_pins_properties.sv */
/* Checker for the event pins; bound to dep_event_pins, sees its ports only. */
`timescale 1ns/1ps
module dep_event_pins_properties
	import dep_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic event_input_pin,
	input wire logic event_output_pin,
	input wire logic debug_entry,
	input wire logic [DEP_UNITS-1:0] unit_hit,
	input wire logic ext_break
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_fall;
		$past(event_input_pin) ##0 !event_input_pin;
	endsequence
	sequence s_low_hold;
		!$past(event_input_pin) ##0 !event_input_pin;
	endsequence
	a_brk_on_fall: assert property (ext_break |-> s_fall)
		else $error("break without falling edge");
	a_brk_single: assert property (ext_break |=> !ext_break)
		else $error("break longer than one cycle");
	a_brk_held_low: assert property (s_low_hold |-> !ext_break)
		else $error("break without new edge");
	a_out_reset_high: assert property ($rose(rst_n) |-> event_output_pin)
		else $error("output low after reset");
	a_low_cause: assert property (!event_output_pin |-> $past(debug_entry) || $past(|unit_hit))
		else $error("output low without cause");
	a_entry_one: assert property ($fell(event_output_pin) && !$past(|unit_hit) |=> event_output_pin
		|| $past(debug_entry) || $past(|unit_hit))
		else $error("entry pulse too long");
endmodule
bind dep_event_pins dep_event_pins_properties u_props (.mclk(mclk), .rst_n(rst_n), .event_input_pin(event_input_pin),
	.event_output_pin(event_output_pin), .debug_entry(debug_entry), .unit_hit(unit_hit), .ext_break(ext_break));

/* File: sim/dep_pulse_src.sv */
/* Pulse source on the event input; idles high, fire starts one low pulse. */
`timescale 1ns/1ps
module dep_pulse_src
(
	input wire logic mclk,
	input wire logic fire,
	input wire logic slow,
	output logic pin
);
	initial pin = 1'b1;
	always @(posedge mclk)
	begin
		if (fire)
		begin
			pin <= 1'b0;
			repeat (slow ? 3 : 1) @(posedge mclk);
			pin <= 1'b1;
		end
	end
endmodule

/* File: sim/dep_event_pins_test.sv */
/* Bench for dep_event_pins; the pulse source drives the event input. */
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module dep_event_pins_test
	import dep_pkg::*;
;
	logic mclk = 0, rst_n = 0, wr = 0, rd = 0, de = 0, fire = 0, pin, eo, brk, irq;
	logic [3:0] addr = 0, hit = 0, eoc;
	logic [31:0] wd = 0, rdata;
	int err_total = 0, n_checks = 0, seed = 32'h7ADC, lows, brks;
	always #20 mclk = ~mclk;
	always @(posedge mclk)
	begin
		lows += !eo;
		brks += brk;
	end
	dep_event_pins u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .event_input_pin(pin), .event_output_pin(eo), .debug_entry(de), .unit_hit(hit),
		.ext_break(brk), .irq(irq));
	dep_pulse_src u_src (.mclk(mclk), .fire(fire), .slow(brks[0]), .pin(pin));
	task wrr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk) {addr, wd, wr} <= {a, d, 1'b1};
		@(posedge mclk) wr <= 0;
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk) {addr, rd} <= {a, 1'b1};
		@(posedge mclk) rd <= 0;
		#1 `CHK("rdata", e, rdata)
	endtask
	task finish_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		finish_test();
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1;
		rdc(4'hF, 0);
		for (int c = 0; c < 4; c++)
		begin
			wrr(DEP_OFF_CTRL, c);
			wrr(DEP_OFF_MASK, 1);
			#1 brks = 0;
			@(posedge mclk) fire <= 1;
			@(posedge mclk) fire <= 0;
			repeat (6) @(posedge mclk);
			#1 `CHK("brk", c == 1, brks)
			`CHK("irq", c == 1, irq)
			rdc(DEP_OFF_STATUS, c == 1);
			wrr(DEP_OFF_STATUS, 7);
		end
		$display("input test done");
		@(posedge mclk) hit <= 4'hF;
		wrr(DEP_OFF_BPEOC, 4'hF);
		for (int s = 0; s < 4; s += (s == 1) ? 2 : 1)
		begin
			wrr(DEP_OFF_CTRL, s << 2);
			#1 lows = 0;
			@(posedge mclk) de <= 1;
			@(posedge mclk) de <= 0;
			repeat (4) @(posedge mclk);
			#1 `CHK("lows", s == 1, lows)
		end
		eoc = 4'($random(seed));
		wrr(DEP_OFF_BPEOC, eoc);
		rdc(DEP_OFF_BPEOC, eoc);
		wrr(DEP_OFF_CTRL, 8);
		wrr(DEP_OFF_STATUS, 7);
		for (int i = 0; i < 30; i++)
		begin
			@(posedge mclk) hit <= $random(seed);
			@(posedge mclk) #1 `CHK("eo", !(hit & eoc), eo)
		end
		$display("output test done");
		finish_test();
	end
endmodule
